/* logic/plrc_top.sv */
// Power loss restart sequencer with APB registers and interrupt
// How it works
// - Mode zero never restarts; a dip only leads to undervoltage detection.
// - Mode one restarts when the bus returns within the ride-through time.
// - Mode one declares the undervoltage fault once the outage outlasts the ride-through time.
// - Mode two restarts whenever the bus returns and never raises the undervoltage fault.
// - Ride-through time is set in tenths of a second, 0 to 25.5 s, reset 0.1 s, used only in mode one.
// - On restart the output stays blocked at least the minimum block time, 0.1 to 5.0 s, reset 0.2 s.
// - After the speed search the output voltage ramps from zero to full over 0.0 to 5.0 s, reset 0.3 s.
// - Undervoltage is the bus voltage below a threshold of 150 to 210 V, reset 190 V.
// - Error outputs stay inactive while a recovery is in progress.
// - In mode zero an outage during operation longer than 15 ms declares the undervoltage fault.
module plrc_top #(
    parameter int TICK_CYCLES = plrc_pkg::TICK_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] bus_voltage_in,
    input wire logic run_cmd_in,
    input wire logic search_done_in,
    input wire logic drive_error_in,
    output logic output_block_out,
    output logic [7:0] voltage_scale_out,
    output logic speed_search_req_out,
    output logic main_circuit_undervoltage_fault_out,
    output logic error_out,
    output logic recovering_out,
    output logic irq_out
);
    import plrc_pkg::*;

    // ****************
    // Declarations
    // ****************
    plrc_timer_if tmr_if ();
    plrc_state_e state_reg;
    plrc_state_e state_next;
    logic [1:0] mode_reg;
    logic [15:0] ride_reg, block_reg, recov_reg, uv_thr_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_en_reg, irq_set;
    logic [2:0] run_sync_reg;
    logic running_reg;
    logic [ELAPSED_W-1:0] block_cnt_reg, ramp_acc_reg, acc_sum;
    logic [ELAPSED_W-1:0] ride_ticks, block_ticks, recov_ticks;
    logic [7:0] scale_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg, block_reg_q, search_reg, fault_out_reg, error_reg;
    logic bus_low, recovering, setup, wr_en, fault_reset;

    // Converts a time in tenths of a second to base ticks
    function automatic logic [ELAPSED_W-1:0] to_ticks(input logic [15:0] tenths);
        to_ticks = ELAPSED_W'(32'(tenths) * TICKS_PER_TENTH);
    endfunction

    // Register value check, a bad value is refused rather than clipped
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ****************
    // Outage timer
    // ****************
    plrc_tick_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .tmr(tmr_if.timer)
    );

    // Timer starts fresh when the bus first drops and runs only while it is low
    assign tmr_if.clear = (state_reg != ST_DIP);
    assign tmr_if.run = bus_low;

    assign bus_low = (bus_voltage_in < uv_thr_reg);
    assign ride_ticks = to_ticks(ride_reg);
    assign block_ticks = to_ticks(block_reg);
    assign recov_ticks = to_ticks(recov_reg);
    // Mode zero keeps driving through a short dip, so it is not a recovery
    assign recovering = ((state_reg == ST_DIP) && (mode_reg != MODE_OFF)) || (state_reg == ST_BLOCK) ||
                        (state_reg == ST_SEARCH) || (state_reg == ST_RAMP);

    // ****************
    // Run command synchroniser
    // ****************
    // Level is accepted only once the last two stages agree
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_sync_reg <= 3'h0;
            running_reg <= 1'b0;
        end else begin
            run_sync_reg <= {run_sync_reg[1:0], run_cmd_in};
            if (run_sync_reg[1] == run_sync_reg[2]) begin
                running_reg <= run_sync_reg[2];
            end
        end
    end

    // ****************
    // Sequencer
    // ****************
    // Next state from bus level, mode and timers
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_NORMAL: begin
                if (bus_low && running_reg) begin
                    state_next = ST_DIP;
                end
            end
            ST_DIP: begin
                if (mode_reg == MODE_OFF) begin
                    if (tmr_if.elapsed > DIP_FAULT_TICKS) begin
                        state_next = ST_FAULT;
                    end else if (!bus_low) begin
                        state_next = ST_NORMAL;
                    end
                end else if ((mode_reg == MODE_TIMED) && (tmr_if.elapsed > ride_ticks)) begin
                    state_next = ST_FAULT;
                end else if (!bus_low) begin
                    state_next = ST_BLOCK;
                end
            end
            ST_BLOCK: begin
                if (!running_reg) begin
                    state_next = ST_NORMAL;
                end else if (block_cnt_reg >= block_ticks) begin
                    state_next = ST_SEARCH;
                end
            end
            ST_SEARCH: begin
                if (!running_reg) begin
                    state_next = ST_NORMAL;
                end else if (search_done_in) begin
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!running_reg || (scale_reg == RAMP_MAX)) begin
                    state_next = ST_NORMAL;
                end
            end
            ST_FAULT: begin
                if (fault_reset && !bus_low) begin
                    state_next = ST_NORMAL;
                end
            end
            default: begin
                state_next = ST_FAULT;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= ST_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // Block time counts from the start of the outage, so dip time is credited
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            block_cnt_reg <= '0;
        end else if ((state_reg != ST_DIP) && (state_reg != ST_BLOCK)) begin
            block_cnt_reg <= '0;
        end else if (tmr_if.tick && (block_cnt_reg != '1)) begin
            block_cnt_reg <= block_cnt_reg + ELAPSED_W'(1);
        end
    end

    // Voltage ramp: error accumulator spreads the steps evenly over the time
    assign acc_sum = ramp_acc_reg + ELAPSED_W'(RAMP_MAX);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scale_reg <= RAMP_MAX;
            ramp_acc_reg <= '0;
        end else if (state_reg == ST_RAMP) begin
            if (recov_ticks == '0) begin
                scale_reg <= RAMP_MAX;
            end else if (tmr_if.tick && (scale_reg != RAMP_MAX)) begin
                if (acc_sum >= recov_ticks) begin
                    ramp_acc_reg <= acc_sum - recov_ticks;
                    scale_reg <= scale_reg + 8'h01;
                end else begin
                    ramp_acc_reg <= acc_sum;
                end
            end
        end else begin
            ramp_acc_reg <= '0;
            // A mode zero dip is no recovery, so the output keeps full voltage through it
            scale_reg <= ((recovering || (state_reg == ST_FAULT)) && (state_next != ST_NORMAL)) ? 8'h00 : RAMP_MAX;
        end
    end

    // Drive outputs, all registered
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            block_reg_q <= 1'b0;
            search_reg <= 1'b0;
            fault_out_reg <= 1'b0;
            error_reg <= 1'b0;
        end else begin
            block_reg_q <= recovering && (state_reg != ST_RAMP) || (state_reg == ST_FAULT);
            search_reg <= (state_reg == ST_SEARCH);
            fault_out_reg <= (state_reg == ST_FAULT) && !recovering;
            error_reg <= ((state_reg == ST_FAULT) || drive_error_in) && !recovering;
        end
    end

    // ****************
    // APB slave
    // ****************
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && !pslverr_reg;
    assign fault_reset = wr_en && (paddr == OFS_CTRL) && pwdata[CTRL_FAULT_RESET];

    // Read data and error decided in the setup phase, so zero wait states
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            unique case (paddr)
                OFS_MODE: begin
                    prdata_reg <= {30'h00000000, mode_reg};
                    pslverr_reg <= pwrite && !in_range(pwdata[15:0], MODE_RST, MODE_MAX);
                end
                OFS_RIDE: begin
                    prdata_reg <= {16'h0000, ride_reg};
                    pslverr_reg <= pwrite && !in_range(pwdata[15:0], 16'h0000, RIDE_MAX);
                end
                OFS_BLOCK: begin
                    prdata_reg <= {16'h0000, block_reg};
                    pslverr_reg <= pwrite && !in_range(pwdata[15:0], BLOCK_MIN, BLOCK_MAX);
                end
                OFS_RECOV: begin
                    prdata_reg <= {16'h0000, recov_reg};
                    pslverr_reg <= pwrite && !in_range(pwdata[15:0], 16'h0000, RECOV_MAX);
                end
                OFS_UV_THR: begin
                    prdata_reg <= {16'h0000, uv_thr_reg};
                    pslverr_reg <= pwrite && !in_range(pwdata[15:0], UV_THR_MIN, UV_THR_MAX);
                end
                OFS_CTRL, OFS_IRQ_CLR: begin
                    prdata_reg <= 32'h00000000;
                end
                OFS_STATUS: begin
                    prdata_reg <= {24'h000000, bus_low, running_reg, recovering, fault_out_reg, 1'b0, state_reg};
                    pslverr_reg <= pwrite;
                end
                OFS_IRQ_STAT: begin
                    prdata_reg <= {29'h00000000, irq_stat_reg};
                    pslverr_reg <= pwrite;
                end
                OFS_IRQ_EN: begin
                    prdata_reg <= {29'h00000000, irq_en_reg};
                end
                default: begin
                    pslverr_reg <= 1'b1;
                end
            endcase
        end
    end

    // Parameter registers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_reg <= MODE_RST[1:0];
            ride_reg <= RIDE_RST;
            block_reg <= BLOCK_RST;
            recov_reg <= RECOV_RST;
            uv_thr_reg <= UV_THR_RST;
            irq_en_reg <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_MODE) mode_reg <= pwdata[1:0];
            if (paddr == OFS_RIDE) ride_reg <= pwdata[15:0];
            if (paddr == OFS_BLOCK) block_reg <= pwdata[15:0];
            if (paddr == OFS_RECOV) recov_reg <= pwdata[15:0];
            if (paddr == OFS_UV_THR) uv_thr_reg <= pwdata[15:0];
            if (paddr == OFS_IRQ_EN) irq_en_reg <= pwdata[IRQ_W-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    assign irq_set[IRQ_DIP] = (state_reg == ST_NORMAL) && (state_next == ST_DIP);
    assign irq_set[IRQ_RESTART] = (state_reg == ST_RAMP) && (state_next == ST_NORMAL);
    assign irq_set[IRQ_FAULT] = (state_reg != ST_FAULT) && (state_next == ST_FAULT);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat_reg <= '0;
        end else if (wr_en && (paddr == OFS_IRQ_CLR)) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign irq_out = |(irq_stat_reg & irq_en_reg);
    assign output_block_out = block_reg_q;
    assign voltage_scale_out = scale_reg;
    assign speed_search_req_out = search_reg;
    assign main_circuit_undervoltage_fault_out = fault_out_reg;
    assign error_out = error_reg;
    assign recovering_out = recovering;

    // ****************
    // Assertions
    // ****************
    sequence s_dip_timed;
        state_reg == ST_DIP && mode_reg == MODE_TIMED;
    endsequence
    sequence s_back_normal;
        state_reg == ST_NORMAL ##1 !output_block_out;
    endsequence

    property p_mode0_no_restart;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_DIP && mode_reg == MODE_OFF && !bus_low && tmr_if.elapsed <= DIP_FAULT_TICKS
        |=> s_back_normal;
    endproperty
    a_mode0_no_restart: assert property (p_mode0_no_restart) else $error("mode 0 dip did not resume");

    property p_timed_restart;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_dip_timed and (!bus_low && tmr_if.elapsed <= ride_ticks) |=> state_reg == ST_BLOCK ##1 output_block_out;
    endproperty
    a_timed_restart: assert property (p_timed_restart) else $error("timed mode failed to restart");

    property p_timed_fault;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_dip_timed and (tmr_if.elapsed > ride_ticks) |=> state_reg == ST_FAULT ##1 main_circuit_undervoltage_fault_out;
    endproperty
    a_timed_fault: assert property (p_timed_fault) else $error("ride-through overrun not faulted");

    property p_always_no_fault;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_DIP && mode_reg == MODE_ALWAYS |=> state_reg != ST_FAULT;
    endproperty
    a_always_no_fault: assert property (p_always_no_fault) else $error("mode 2 raised undervoltage fault");

    property p_block_min;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_BLOCK && block_cnt_reg < block_ticks |=> state_reg != ST_SEARCH;
    endproperty
    a_block_min: assert property (p_block_min) else $error("block time cut short");

    property p_ramp_rises;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_RAMP && scale_reg != RAMP_MAX && recov_ticks != '0 |=> scale_reg >= $past(scale_reg);
    endproperty
    a_ramp_rises: assert property (p_ramp_rises) else $error("voltage ramp went down");

    property p_uv_detect;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_NORMAL && running_reg && bus_voltage_in < uv_thr_reg |=> state_reg == ST_DIP;
    endproperty
    a_uv_detect: assert property (p_uv_detect) else $error("undervoltage not detected");

    property p_error_quiet;
        @(posedge core_clk_in) disable iff (!resetn_in)
        recovering |=> !error_out && !main_circuit_undervoltage_fault_out;
    endproperty
    a_error_quiet: assert property (p_error_quiet) else $error("error output during recovery");

    property p_mode0_fault;
        @(posedge core_clk_in) disable iff (!resetn_in)
        state_reg == ST_DIP && mode_reg == MODE_OFF && tmr_if.elapsed > DIP_FAULT_TICKS |=> state_reg == ST_FAULT;
    endproperty
    a_mode0_fault: assert property (p_mode0_fault) else $error("15 ms outage not faulted");
endmodule

/* logic/plrc_pkg.sv */
// Constants, register map and state codes of the power loss restart control
package plrc_pkg;
    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_TIME_NS = 100_000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int TENTH_TIME_NS = 100_000_000;
    localparam int TICKS_PER_TENTH = TENTH_TIME_NS / TICK_TIME_NS;
    localparam int DIP_FAULT_TIME_NS = 15_000_000;
    localparam int ELAPSED_W = 20;
    localparam logic [ELAPSED_W-1:0] DIP_FAULT_TICKS = ELAPSED_W'(DIP_FAULT_TIME_NS / TICK_TIME_NS);
    localparam logic [7:0] RAMP_MAX = 8'hFF;
    // ****************
    // Register map
    // ****************
    localparam logic [11:0] OFS_MODE = 12'h000;
    localparam logic [11:0] OFS_RIDE = 12'h004;
    localparam logic [11:0] OFS_BLOCK = 12'h008;
    localparam logic [11:0] OFS_RECOV = 12'h00C;
    localparam logic [11:0] OFS_UV_THR = 12'h010;
    localparam logic [11:0] OFS_CTRL = 12'h014;
    localparam logic [11:0] OFS_STATUS = 12'h018;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h01C;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h020;
    localparam logic [11:0] OFS_IRQ_EN = 12'h024;
    // Parameter reset values and legal ranges, times in tenths of a second
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] MODE_MAX = 16'h0002;
    localparam logic [15:0] RIDE_RST = 16'h0001;
    localparam logic [15:0] RIDE_MAX = 16'h00FF;
    localparam logic [15:0] BLOCK_RST = 16'h0002;
    localparam logic [15:0] BLOCK_MIN = 16'h0001;
    localparam logic [15:0] BLOCK_MAX = 16'h0032;
    localparam logic [15:0] RECOV_RST = 16'h0003;
    localparam logic [15:0] RECOV_MAX = 16'h0032;
    localparam logic [15:0] UV_THR_RST = 16'h00BE;
    localparam logic [15:0] UV_THR_MIN = 16'h0096;
    localparam logic [15:0] UV_THR_MAX = 16'h00D2;
    // Field positions
    localparam int CTRL_FAULT_RESET = 0;
    localparam int IRQ_DIP = 0;
    localparam int IRQ_RESTART = 1;
    localparam int IRQ_FAULT = 2;
    localparam int IRQ_W = 3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TIMED = 2'h1;
    localparam logic [1:0] MODE_ALWAYS = 2'h2;
    // ****************
    // States
    // ****************
    typedef enum logic [2:0] {
        ST_NORMAL = 3'h0,
        ST_DIP = 3'h1,
        ST_BLOCK = 3'h3,
        ST_SEARCH = 3'h2,
        ST_RAMP = 3'h6,
        ST_FAULT = 3'h7
    } plrc_state_e;
endpackage

/* logic/plrc_timer_if.sv */
// Link between the restart sequencer and its outage timer
interface plrc_timer_if;
    import plrc_pkg::*;
    logic clear;
    logic run;
    logic tick;
    logic [ELAPSED_W-1:0] elapsed;
    modport owner(output clear, output run, input tick, input elapsed);
    modport timer(input clear, input run, output tick, output elapsed);
endinterface

/* logic/plrc_tick_timer.sv */
// Base tick prescaler and saturating outage timer
module plrc_tick_timer #(
    parameter int TICK_CYCLES = plrc_pkg::TICK_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    plrc_timer_if.timer tmr
);
    import plrc_pkg::*;
    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
    logic [23:0] pre_reg;
    logic tick_reg;
    logic [ELAPSED_W-1:0] elapsed_reg;

    // Free running prescaler, one tick per base period
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_reg <= 24'h000000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (pre_reg == TICK_LAST);
            pre_reg <= (pre_reg == TICK_LAST) ? 24'h000000 : pre_reg + 24'h000001;
        end
    end

    // Elapsed count; saturates so a very long outage never wraps to short
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            elapsed_reg <= '0;
        end else if (tmr.clear) begin
            elapsed_reg <= '0;
        end else if (tmr.run && tick_reg && (elapsed_reg != '1)) begin
            elapsed_reg <= elapsed_reg + ELAPSED_W'(1);
        end
    end

    assign tmr.tick = tick_reg;
    assign tmr.elapsed = elapsed_reg;
endmodule

/* test/plrc_partner.sv */
// Model of the run command source and DC bus sensing
module plrc_partner (
    input wire logic core_clk_in,
    input wire logic search_req_in,
    output logic [15:0] bus_voltage_out,
    output logic run_cmd_out,
    output logic search_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int search_delay = 5;
    int cnt = 0;
    // Healthy bus, run latched from the start
    initial begin
        bus_voltage_out = 16'h012C;
        run_cmd_out = 1'b1;
        search_done_out = 1'b0;
    end
    // Bus sags for n cycles; run stays asserted so the drive can resume
    task automatic dip(input int n, input logic [15:0] lvl);
        @(posedge core_clk_in);
        bus_voltage_out <= lvl;
        repeat (n) @(posedge core_clk_in);
        bus_voltage_out <= 16'h012C;
    endtask
    // Search finishes a few cycles after the request, as a one-cycle pulse
    always @(posedge core_clk_in) begin
        cnt <= search_req_in ? cnt + 1 : 0;
        search_done_out <= search_req_in && cnt == search_delay;
    end
endmodule

/* test/tb.sv */
// Self-checking bench of the power loss restart control
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import plrc_pkg::*;
    localparam int TK = 4;
    localparam int TENTH = TK * 1000;
    logic core_clk_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0, drive_error_in = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, run_cmd, search_done, oblk, sreq, fault, error_out, recov, irq;
    logic [15:0] bus_v;
    logic [15:0] lfsr = 16'h000F;
    logic [7:0] vscale;
    int n_fail = 0, num_checks = 0, cyc = 0, n;
    int exp_reg[5] = '{0, 1, 2, 3, 190};
    plrc_top #(.TICK_CYCLES(TK)) i_plrc_top (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_voltage_in(bus_v), .run_cmd_in(run_cmd), .search_done_in(search_done),
        .drive_error_in(drive_error_in), .output_block_out(oblk), .voltage_scale_out(vscale),
        .speed_search_req_out(sreq), .main_circuit_undervoltage_fault_out(fault), .error_out(error_out),
        .recovering_out(recov), .irq_out(irq));
    plrc_partner i_plrc_partner (.core_clk_in(core_clk_in), .search_req_in(sreq), .bus_voltage_out(bus_v),
        .run_cmd_out(run_cmd), .search_done_out(search_done));
    // 250 MHz clock
    always #2 core_clk_in = ~core_clk_in;
    // Hang guard, well above the roughly 25k cycles the sequence needs
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Next LFSR state, taps of a maximal 16-bit sequence
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do @(posedge core_clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write, check the response, and track legal values in the register model
    task automatic wr(input logic [11:0] a, input int d, input logic e);
        apb(1'b1, a, 32'(d));
        chk(err, e);
        if (!e && a < OFS_CTRL) exp_reg[a >> 2] = d;
    endtask
    task automatic rdchk(input logic [11:0] a);
        apb(1'b0, a, '0);
        chk(rd, exp_reg[a >> 2]);
    endtask
    // Waits for a sequencer output to reach v, counting cycles
    task automatic wt(input int s, input logic v, output int c);
        c = 0;
        while ((s == 0 ? sreq : s == 1 ? oblk : s == 2 ? fault : &vscale) !== v) begin
            @(posedge core_clk_in);
            c++;
        end
    endtask
    // Sag level drawn below the threshold from the LFSR
    task automatic sag(input int len);
        lfsr = lfsr_next(lfsr);
        i_plrc_partner.dip(len, 16'(exp_reg[4] - 1 - lfsr % 40));
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        foreach (exp_reg[i]) rdchk(12'(i * 4));
        apb(1'b0, 12'h040, '0);
        chk({rd[0], err}, 2'h1);
        wr(OFS_UV_THR, 211, 1'b1);
        wr(OFS_UV_THR, 150, 1'b0);
        wr(OFS_UV_THR, 149, 1'b1);
        rdchk(OFS_UV_THR);
        wr(OFS_UV_THR, 190, 1'b0);
        wr(OFS_STATUS, 0, 1'b1);
        wr(OFS_MODE, 3, 1'b1);
        wr(OFS_BLOCK, 0, 1'b1);
        wr(OFS_BLOCK, 1, 1'b0);
        wr(OFS_RECOV, 1, 1'b0);
        wr(OFS_IRQ_EN, 4, 1'b0);
        sag(200);
        chk({fault, oblk, vscale}, {2'h0, RAMP_MAX});
        sag(1000);
        chk({fault, irq}, 2'h3);
        wr(OFS_IRQ_EN, 0, 1'b0);
        // The enable lands at the access edge; look once it has settled
        @(negedge core_clk_in);
        chk(irq, 0);
        wr(OFS_CTRL, 1, 1'b0);
        wr(OFS_IRQ_CLR, 7, 1'b0);
        chk(fault, 0);
        // Timed mode, short sag: blocked, then search, then ramp
        wr(OFS_MODE, 1, 1'b0);
        drive_error_in <= 1'b1;
        fork sag(400); join_none
        wt(0, 1'b1, n);
        chk(n > TENTH - 8 && n < TENTH + 24, 1);
        chk({error_out, recov, oblk}, 3'h3);
        // Block lifts as the ramp starts, then the voltage climbs over the recovery time
        wt(1, 1'b0, n);
        chk(n < 24, 1);
        wt(3, 1'b1, n);
        chk(n > TENTH - 8 && n < TENTH + 24, 1);
        chk(vscale, RAMP_MAX);
        repeat (3) @(posedge core_clk_in);
        chk(error_out, 1);
        drive_error_in <= 1'b0;
        apb(1'b0, OFS_IRQ_STAT, '0);
        chk(rd[2:0], 3'h3);
        sag(5000);
        chk(fault, 1);
        wr(OFS_CTRL, 1, 1'b0);
        // Always mode: long sag still restarts, never faults
        wr(OFS_MODE, 2, 1'b0);
        sag(5000);
        chk({fault, oblk}, 2'h1);
        wt(3, 1'b1, n);
        chk({fault, vscale}, {1'b0, RAMP_MAX});
        test_done();
    end
endmodule
